// ---- src/fsio_out_cvt.sv ----
// clamp and format conversion of one shader colour component
`timescale 1ns/1ps
`default_nettype none
`include "fsio_params.svh"
module fsio_out_cvt (
  input wire logic [31:0] val, // shader component
  input wire logic clampEn, // colour clamp enable
  input wire fsio_pkg::fsio_fmt_t fmt, // target format
  input wire logic srcInt, // output declared integer
  output logic [31:0] res // value for the target
);
  import fsio_pkg::*;
  logic clampOn;
  logic [31:0] v;
  logic [7:0] mag;
  logic [23:0] norm;

  // integer outputs or targets are never clamped
  assign clampOn = clampEn && fmt != FSIO_FMT_INT && !srcInt;
  assign v = clampOn ? fsio_clamp01(val) : val;
  assign norm = fsio_to_norm(v, (fmt == FSIO_FMT_SNORM) ? `FSIO_S8_MAX : `FSIO_U8_MAX);
  assign mag = norm[7:0];

  // normalized targets get fixed point, others pass the bits of v, clamped only for float
  always_comb begin
    unique case (fmt)
      FSIO_FMT_UNORM: res = {24'h000000, mag};
      FSIO_FMT_SNORM: res = {24'h000000, v[31] ? 8'(-mag) : mag};
      FSIO_FMT_FLOAT, FSIO_FMT_INT: res = v;
    endcase
  end
endmodule : fsio_out_cvt
`default_nettype wire

// ---- src/fsio_params.svh ----
// constants for the fragment shader i/o stage
// Summary of operation
// - x minus half under integer centres
// - y flipped for upper-left, then minus half under integer centres
// - depth passes unchanged, 0 and 1 exact
// - fourth component is reciprocal of clip w
// - default half-integer centres, lower-left origin
// - fixed colours to float, 0/1 exact
// - front flag from signed area and winding
// - geometry stage index replaces own counter
// - counter zeroed at begin, counts primitives
// - one count per polygon or quad
// - primitive restart leaves counter alone
// - index undefined for polygons and pixels
// - clamp float colours when enabled, non-integer target
// - no clamp when disabled or integer
// - shader depth clamped, fixed or float
// - normalized targets convert float to fixed
// - rasterizer depth unless shader writes depth
// - primary to colour zero, outputs to numbers
// - binding at or above limit flags error
// - link refuses aliasing or too many outputs
`ifndef FSIO_PARAMS_SVH
`define FSIO_PARAMS_SVH
`define FSIO_FRAC 4
`define FSIO_HALF 16'h0008
`define FSIO_ONE_F 32'h3F800000
`define FSIO_NOUT 4
`define FSIO_NCOMP 4
`define FSIO_CW 32
`define FSIO_MANT 23
`define FSIO_RCP_STEPS 6'h20
`define FSIO_RCP_MAX 32'hFFFFFFFF
`define FSIO_U8_MAX 24'h0000FF
`define FSIO_S8_MAX 24'h00007F
`define FSIO_Z_MAX 24'hFFFFFF
`define FSIO_U8_SPREAD 24'h010101
`define FSIO_EXP_BIAS 8'h7F
`define FSIO_EXP_BASE 8'h67
`define FSIO_RND 48'h000000400000
`define FSIO_NO_LOC 8'hFF
`define FSIO_NLOC 8
`endif

// ---- src/fsio_pkg.sv ----
// types and float helpers for the fragment shader i/o stage
`include "fsio_params.svh"
package fsio_pkg;
  typedef enum logic [1:0] {FSIO_FMT_UNORM, FSIO_FMT_SNORM, FSIO_FMT_FLOAT,
                            FSIO_FMT_INT} fsio_fmt_t;
  typedef enum logic [1:0] {FSIO_IDLE, FSIO_DIV, FSIO_SEND} fsio_st_t;
  typedef logic [`FSIO_NCOMP-1:0][`FSIO_CW-1:0] fsio_rgba_t;
  typedef fsio_rgba_t [`FSIO_NOUT-1:0] fsio_targets_t;
  typedef struct packed {
    logic busy; logic done; logic [5:0] cnt;
    logic [32:0] rem; logic [31:0] d; logic [31:0] q;
  } fsio_rcp_t;
  typedef struct packed {
    fsio_st_t st; logic inRdy; logic rcpStart; logic wcNeg; logic [31:0] wcMag;
    logic fsV; logic [15:0] posX; logic [15:0] posY; logic [31:0] posZ;
    logic [31:0] posW; fsio_rgba_t pri; fsio_rgba_t sec; logic front;
    logic [31:0] primId; logic [31:0] primCnt;
    logic shRdy; logic outV; fsio_targets_t outCol; logic [31:0] outDep;
    logic [`FSIO_NOUT-1:0][7:0] pend; logic [`FSIO_NOUT-1:0] pendSet;
    logic [`FSIO_NOUT-1:0][7:0] link; logic [`FSIO_NOUT-1:0] linkAct; logic linked;
    logic bErr; logic lDone; logic lFail; logic [7:0] qNum;
  } fsio_state_t;

  // unorm8 to float; ends forced so 0 and 1 come out exact
  function automatic logic [31:0] fsio_u8_to_f(input logic [7:0] n);
    logic [23:0] f;
    logic [7:0] e;
    logic [22:0] m;
    f = 24'(n * `FSIO_U8_SPREAD);
    e = 8'h00;
    m = 23'h000000;
    for (int p = 0; p < $bits(f); p++) begin
      if (f[p]) begin
        e = 8'(`FSIO_EXP_BASE + p);
        m = 23'(f << ($bits(m) - p));
      end
    end
    if (n == 8'h00) return 32'h00000000;
    if (n == 8'hFF) return `FSIO_ONE_F;
    return {1'b0, e, m};
  endfunction : fsio_u8_to_f

  // positive floats order like integers, so a plain compare clamps
  function automatic logic [31:0] fsio_clamp01(input logic [31:0] v);
    if (v[31]) return 32'h00000000;
    if (v > `FSIO_ONE_F) return `FSIO_ONE_F;
    return v;
  endfunction : fsio_clamp01

  // magnitude of v times full scale, rounded; saturates at one
  function automatic logic [23:0] fsio_to_norm(input logic [31:0] v, input logic [23:0] full);
    logic [23:0] fr;
    logic [47:0] pr;
    fr = {1'b1, v[22:0]} >> (`FSIO_EXP_BIAS - v[30:23]);
    pr = 48'(fr * full) + `FSIO_RND;
    if (v[30:23] >= `FSIO_EXP_BIAS) return full;
    return 24'(pr >> `FSIO_MANT);
  endfunction : fsio_to_norm
endpackage : fsio_pkg

// ---- src/fsio_recip.sv ----
// iterative reciprocal of clip w, Q16.16 in and out
`timescale 1ns/1ps
`default_nettype none
`include "fsio_params.svh"
module fsio_recip (
  input wire logic clk, // pipeline clock
  input wire logic srst, // sync reset
  input wire logic start, // one-cycle start
  input wire logic [31:0] divisor, // |wc|, Q16.16
  output logic done, // one-cycle result pulse
  output logic [31:0] quotient // 1/|wc|, Q16.16
);
  import fsio_pkg::*;
  fsio_rcp_t r, next_r;

  // restoring division of 2^32 by divisor, one bit per cycle
  always_comb begin
    logic [32:0] t;
    t = {r.rem[31:0], 1'b0};
    next_r = r;
    next_r.done = 1'b0;
    if (start) begin
      next_r.d = divisor;
      next_r.q = 32'h00000000;
      next_r.rem = 33'h000000001;
      next_r.cnt = `FSIO_RCP_STEPS;
      next_r.busy = divisor > 32'h00000001;
      // tiny or zero w would overflow, so saturate instead
      if (divisor <= 32'h00000001) begin
        next_r.q = `FSIO_RCP_MAX;
        next_r.done = 1'b1;
      end
    end else if (r.busy) begin
      next_r.q = {r.q[30:0], t >= {1'b0, r.d}};
      next_r.rem = (t >= {1'b0, r.d}) ? t - {1'b0, r.d} : t;
      next_r.cnt = r.cnt - 6'h01;
      if (r.cnt == 6'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (srst) r <= '0;
    else r <= next_r;
  end

  assign done = r.done;
  assign quotient = r.q;
endmodule : fsio_recip
`default_nettype wire

// ---- src/fsio_stage.sv ----
// fragment shader input build and output resolve stage
`timescale 1ns/1ps
`default_nettype none
`include "fsio_params.svh"
module fsio_stage (
  input wire logic clk, // pipeline clock
  input wire logic srst, // sync reset
  input wire logic cfgIntCenter, // integer pixel centres
  input wire logic cfgUpperLeft, // upper-left origin
  input wire logic [15:0] cfgHeight, // window height, pixels
  input wire logic cfgClampEn, // colour clamp enable
  input wire fsio_pkg::fsio_fmt_t cfgColourFmt, // colour target format
  input wire logic cfgDepthFloat, // depth buffer is float
  input wire logic cfgWindingRev, // winding select reversal
  input wire logic cfgGeomActive, // geometry stage present
  input wire logic cfgColourIsFloat, // input colours already float
  input wire logic [2:0] cfgDrawLimit, // draw-target limit
  input wire logic cfgWritesDepth, // program assigns depth
  input wire logic cfgPrimaryOnly, // program writes primary colour
  input wire logic [3:0] cfgOutIsInt, // output declared integer
  input wire logic drawBegin, // drawing begin pulse
  input wire logic primEnd, // primitive processed pulse
  input wire logic primPartial, // part of a larger primitive
  input wire logic primRestart, // restart index seen
  input wire logic inValid, // raster fragment valid
  output logic inReady, // raster fragment ready
  input wire logic [15:0] inX, // window x, Q12.4
  input wire logic [15:0] inY, // window y, Q12.4
  input wire logic [31:0] inZ, // window depth
  input wire logic [31:0] inWc, // clip w, signed Q16.16
  input wire fsio_pkg::fsio_rgba_t inPrimary, // primary colour
  input wire fsio_pkg::fsio_rgba_t inSecondary, // secondary colour
  input wire logic inFromPoly, // from a polygon-type primitive
  input wire logic inAreaNeg, // signed area negative
  input wire logic inAreaZero, // signed area zero
  input wire logic [31:0] inGeomPrimId, // geometry stage index
  output logic fsValid, // shader input valid
  input wire logic fsReady, // shader input ready
  output logic [15:0] fsPosX, // position x
  output logic [15:0] fsPosY, // position y
  output logic [31:0] fsPosZ, // position z
  output logic [31:0] fsPosW, // 1/wc, Q16.16
  output fsio_pkg::fsio_rgba_t fsPrimary, // primary colour, float
  output fsio_pkg::fsio_rgba_t fsSecondary, // secondary colour, float
  output logic fsFront, // front face flag
  output logic [31:0] fsPrimId, // primitive index
  input wire logic shValid, // shader result valid
  output logic shReady, // shader result ready
  input wire fsio_pkg::fsio_targets_t shColour, // shader outputs
  input wire logic [31:0] shDepth, // shader depth, float
  input wire logic [31:0] shRasterDepth, // rasterizer depth
  output logic outValid, // downstream valid
  input wire logic outReady, // downstream ready
  output fsio_pkg::fsio_targets_t outColour, // colours by number
  output logic [31:0] outDepth, // resolved depth
  input wire logic bindValid, // bind request pulse
  input wire logic [1:0] bindVar, // output variable
  input wire logic [7:0] bindNumber, // colour number
  output logic bindError, // invalid value pulse
  input wire logic linkValid, // program link pulse
  input wire logic [3:0] linkActive, // active outputs
  output logic linkDone, // link finished pulse
  output logic linkFail, // last link refused
  input wire logic [1:0] queryVar, // output to query
  output logic [7:0] queryNumber // bound number or FF
);
  import fsio_pkg::*;
  fsio_state_t s, next_s;
  logic rcpDone;
  logic [31:0] rcpQ;
  fsio_targets_t routed;
  fsio_targets_t conv;
  logic [`FSIO_NOUT-1:0] routedInt;
  logic [31:0] zClamp;
  logic [31:0] zOut;
  logic [7:0] lim;
  logic [15:0] yFlip;

  assign lim = {5'h00, cfgDrawLimit};
  // centre and origin 0/0 give the default half-integer, lower-left
  assign yFlip = cfgUpperLeft ? 16'(cfgHeight << `FSIO_FRAC) - inY : inY;

  fsio_recip u_recip (
    .clk(clk),
    .srst(srst),
    .start(s.rcpStart),
    .divisor(s.wcMag),
    .done(rcpDone),
    .quotient(rcpQ)
  );

  // send each linked output to its colour number
  always_comb begin
    routed = '0;
    routedInt = '0;
    for (int c = 0; c < `FSIO_NOUT; c++) begin
      for (int i = 0; i < `FSIO_NOUT; i++) begin
        if (s.linked && s.linkAct[i] && s.link[i] == 8'(c)) begin
          routed[c] = shColour[i];
          routedInt[c] = cfgOutIsInt[i];
        end
      end
    end
    if (cfgPrimaryOnly) begin
      routed[0] = shColour[0];
      routedInt[0] = cfgOutIsInt[0];
    end
  end

  for (genvar c = 0; c < `FSIO_NOUT; c++) begin : g_tgt
    for (genvar k = 0; k < `FSIO_NCOMP; k++) begin : g_cmp
      fsio_out_cvt u_cvt (
        .val(routed[c][k]),
        .clampEn(cfgClampEn),
        .fmt(cfgColourFmt),
        .srcInt(routedInt[c]),
        .res(conv[c][k])
      );
    end
  end

  // depth range mapping is not applied, only clamp and conversion
  assign zClamp = fsio_clamp01(shDepth);
  assign zOut = !cfgWritesDepth ? shRasterDepth :
                cfgDepthFloat ? zClamp : {8'h00, fsio_to_norm(zClamp, `FSIO_Z_MAX)};

  // next state of the whole stage
  always_comb begin
    logic [`FSIO_NLOC-1:0] used;
    logic [3:0] cnt;
    logic bad;
    logic fnd;
    logic [`FSIO_NOUT-1:0][7:0] tbl;
    used = '0;
    cnt = 4'h0;
    bad = 1'b0;
    fnd = 1'b0;
    tbl = s.pend;
    next_s = s;
    next_s.rcpStart = 1'b0;
    next_s.bErr = 1'b0;
    next_s.lDone = 1'b0;

    // primitive counter; a restart has no term here on purpose
    if (drawBegin) next_s.primCnt = 32'h00000000;
    else if (primEnd && !primPartial) next_s.primCnt = s.primCnt + 32'h00000001;

    // input side: capture, divide, offer to the shader
    unique case (s.st)
      FSIO_IDLE: begin
        if (inValid && s.inRdy) begin
          next_s.inRdy = 1'b0;
          next_s.st = FSIO_DIV;
          next_s.rcpStart = 1'b1;
          next_s.wcNeg = inWc[31];
          next_s.wcMag = inWc[31] ? 32'(-inWc) : inWc;
          next_s.posX = cfgIntCenter ? inX - `FSIO_HALF : inX;
          next_s.posY = cfgIntCenter ? yFlip - `FSIO_HALF : yFlip;
          next_s.posZ = inZ;
          for (int k = 0; k < `FSIO_NCOMP; k++) begin
            next_s.pri[k] = cfgColourIsFloat ? inPrimary[k] : fsio_u8_to_f(inPrimary[k][7:0]);
            next_s.sec[k] = cfgColourIsFloat ? inSecondary[k] : fsio_u8_to_f(inSecondary[k][7:0]);
          end
          // zero area counts as back facing
          next_s.front = !inFromPoly || (!inAreaZero && !(inAreaNeg ^ cfgWindingRev));
          // counter value stands for polygon and pixel fragments too, it is undefined there
          next_s.primId = cfgGeomActive ? inGeomPrimId : s.primCnt;
        end
      end
      FSIO_DIV: begin
        if (rcpDone) begin
          next_s.posW = s.wcNeg ? 32'(-rcpQ) : rcpQ;
          next_s.fsV = 1'b1;
          next_s.st = FSIO_SEND;
        end
      end
      FSIO_SEND: begin
        if (fsReady) begin
          next_s.fsV = 1'b0;
          next_s.inRdy = 1'b1;
          next_s.st = FSIO_IDLE;
        end
      end
      default: next_s.st = FSIO_IDLE;
    endcase

    // output side: one slot, so order is kept at half rate
    if (shValid && s.shRdy) begin
      next_s.outCol = conv;
      next_s.outDep = zOut;
      next_s.outV = 1'b1;
      next_s.shRdy = 1'b0;
    end else if (s.outV && outReady) begin
      next_s.outV = 1'b0;
      next_s.shRdy = 1'b1;
    end

    // binding takes effect only at the next link
    if (bindValid) begin
      if (bindNumber >= lim) next_s.bErr = 1'b1;
      else begin
        next_s.pend[bindVar] = bindNumber;
        next_s.pendSet[bindVar] = 1'b1;
      end
    end

    // link: explicit bindings first, then lowest free numbers
    if (linkValid) begin
      for (int i = 0; i < `FSIO_NOUT; i++) begin
        cnt = cnt + 4'(linkActive[i]);
        if (linkActive[i] && s.pendSet[i]) begin
          if (used[s.pend[i][2:0]]) bad = 1'b1;
          used[s.pend[i][2:0]] = 1'b1;
        end
      end
      for (int i = 0; i < `FSIO_NOUT; i++) begin
        fnd = !(linkActive[i] && !s.pendSet[i]);
        for (int c = 0; c < `FSIO_NLOC; c++) begin
          if (!fnd && !used[c] && 8'(c) < lim) begin
            tbl[i] = 8'(c);
            used[c] = 1'b1;
            fnd = 1'b1;
          end
        end
        if (!fnd) bad = 1'b1;
      end
      if ({4'h0, cnt} > lim) bad = 1'b1;
      next_s.lDone = 1'b1;
      next_s.lFail = bad;
      next_s.linked = !bad;
      if (!bad) begin
        next_s.link = tbl;
        next_s.linkAct = linkActive;
      end
    end
    next_s.qNum = (s.linked && s.linkAct[queryVar]) ? s.link[queryVar] : `FSIO_NO_LOC;
  end

  // state register; configuration is assumed steady while fragments flow
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.inRdy <= 1'b1;
      s.shRdy <= 1'b1;
      s.qNum <= `FSIO_NO_LOC;
    end else begin
      s <= next_s;
    end
  end

  assign inReady = s.inRdy;
  assign fsValid = s.fsV;
  assign fsPosX = s.posX;
  assign fsPosY = s.posY;
  assign fsPosZ = s.posZ;
  assign fsPosW = s.posW;
  assign fsPrimary = s.pri;
  assign fsSecondary = s.sec;
  assign fsFront = s.front;
  assign fsPrimId = s.primId;
  assign shReady = s.shRdy;
  assign outValid = s.outV;
  assign outColour = s.outCol;
  assign outDepth = s.outDep;
  assign bindError = s.bErr;
  assign linkDone = s.lDone;
  assign linkFail = s.lFail;
  assign queryNumber = s.qNum;

  // checks on the stage behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  pos_x_a: assert property (inValid && inReady |=> fsPosX ==
    ($past(cfgIntCenter) ? $past(inX) - `FSIO_HALF : $past(inX))) else $error("bad x");
  pos_y_a: assert property (inValid && inReady && !cfgUpperLeft && !cfgIntCenter
    |=> fsPosY == $past(inY)) else $error("bad y");
  depth_pass_a: assert property (inValid && inReady |=> fsPosZ == $past(inZ)
    ) else $error("depth altered");
  recip_time_a: assert property (inValid && inReady |-> ##[2:36] fsValid
    ) else $error("reciprocal late");
  front_flag_a: assert property (inValid && inReady |=> fsFront == (!$past(inFromPoly) ||
    (!$past(inAreaZero) && !($past(inAreaNeg) ^ $past(cfgWindingRev))))) else $error("bad face");
  prim_zero_a: assert property (drawBegin |=> s.primCnt == 32'h00000000
    ) else $error("counter not zeroed");
  prim_hold_a: assert property (!drawBegin && (!primEnd || primPartial)
    |=> $stable(s.primCnt)) else $error("counter moved");
  restart_hold_a: assert property (primRestart && !drawBegin && !primEnd
    |=> $stable(s.primCnt)) else $error("restart moved counter");
  bind_err_a: assert property (bindValid && bindNumber >= lim |=> bindError
    ) else $error("bad binding accepted");
  link_many_a: assert property (linkValid && $countones(linkActive) > cfgDrawLimit
    |=> linkFail && linkDone) else $error("oversize link passed");
  rast_depth_a: assert property (shValid && shReady && !cfgWritesDepth
    |=> outValid && outDepth == $past(shRasterDepth)) else $error("depth source");
  out_hold_a: assert property (outValid && !outReady |=> outValid &&
    $stable(outColour) && $stable(outDepth)) else $error("output dropped");
  fs_hold_a: assert property (fsValid && !fsReady |=> fsValid && $stable(fsPosW)
    ) else $error("shader input dropped");

  frag_in_c: cover property (inValid && inReady ##[2:36] fsValid && fsReady);
  frag_out_c: cover property (shValid && shReady ##1 outValid && outReady);
  bind_err_c: cover property (bindValid ##1 bindError);
  link_ok_c: cover property (linkValid ##1 linkDone && !linkFail);
endmodule : fsio_stage
`default_nettype wire

// ---- verification/fsio_far_model.sv ----
// ready side of the shader and of the downstream stage, prompt or stalling
`timescale 1ns/1ps
`default_nettype none
module fsio_far_model (
  input wire logic clk, // pipeline clock
  input wire logic srst, // sync reset
  input wire logic stall, // hold ready back for a while
  input wire logic fsValid, // shader input valid
  output logic fsReady, // shader input ready
  input wire logic outValid, // downstream valid
  output logic outReady // downstream ready
);
  logic [2:0] fsWait;
  logic [2:0] outWait;
  // count how long a valid has waited; cleared on each handshake
  always_ff @(posedge clk) begin
    fsWait <= (srst || !fsValid || fsReady) ? 3'h0 : fsWait + 3'h1;
    outWait <= (srst || !outValid || outReady) ? 3'h0 : outWait + 3'h1;
  end
  // ready only answers a valid, so a stall really holds the stage
  assign fsReady = fsValid && (!stall || fsWait == 3'h4);
  assign outReady = outValid && (!stall || outWait == 3'h4);
endmodule : fsio_far_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the fragment shader i/o stage
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fsio_pkg::*;
  logic clk = 1'h0, srst = 1'h1, stall = 1'h0;
  logic cfgIntCenter = 1'h0, cfgUpperLeft = 1'h0, cfgClampEn = 1'h0, cfgDepthFloat = 1'h0;
  logic cfgWindingRev = 1'h0, cfgGeomActive = 1'h0, cfgColourIsFloat = 1'h0;
  logic cfgWritesDepth = 1'h0, cfgPrimaryOnly = 1'h1;
  logic [15:0] cfgHeight = 16'h0064, inX = '0, inY = '0, fsPosX, fsPosY;
  logic [2:0] cfgDrawLimit = 3'h4;
  logic [3:0] cfgOutIsInt = '0, linkActive = '0;
  fsio_fmt_t cfgColourFmt = FSIO_FMT_FLOAT;
  logic drawBegin = 1'h0, primEnd = 1'h0, primPartial = 1'h0, primRestart = 1'h0;
  logic inValid = 1'h0, inFromPoly = 1'h0, inAreaNeg = 1'h0, inAreaZero = 1'h0;
  logic inReady, fsValid, fsReady, fsFront, shReady, outValid, outReady;
  logic [31:0] inZ = '0, inWc = '0, inGeomPrimId = '0, fsPosZ, fsPosW, fsPrimId;
  fsio_rgba_t inPrimary = '0, inSecondary = '0, fsPrimary, fsSecondary;
  logic shValid = 1'h0, bindValid = 1'h0, linkValid = 1'h0, bindError, linkDone, linkFail;
  fsio_targets_t shColour = '0, outColour;
  logic [31:0] shDepth = '0, shRasterDepth = '0, outDepth;
  logic [1:0] bindVar = '0, queryVar = '0;
  logic [7:0] bindNumber = '0, queryNumber;
  int failCount = 0, totalChecks = 0;

  fsio_stage i_fsio_stage (.*);
  fsio_far_model i_fsio_far_model (.*);

  always #2.5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // all driving happens 1 ns after the edge, never on it
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // leading edge keeps back-to-back pulses from rewriting in one step
  task automatic pulse(ref logic s);
    step();
    s = 1'h1;
    step();
    s = 1'h0;
  endtask : pulse

  // one raster fragment in; returns while the shader-side copy stands
  task automatic frag(input logic [15:0] x, input logic [15:0] y, input logic [31:0] wc);
    int n;
    n = 0;
    inX = x;
    inY = y;
    inWc = wc;
    inValid = 1'h1;
    while (inReady !== 1'h1) step();
    step();
    inValid = 1'h0;
    while (fsValid !== 1'h1 && n < 60) begin
      step();
      n++;
    end
    chk(fsValid, 1'h1);
  endtask : frag

  // one shader result in; returns while the downstream copy stands
  task automatic shade();
    step();
    shValid = 1'h1;
    while (shReady !== 1'h1) step();
    step();
    shValid = 1'h0;
    chk(outValid, 1'h1);
  endtask : shade

  task automatic testCoords();
    // config only changes between fragments, never with one in flight
    for (int k = 0; k < 4; k++) begin
      cfgIntCenter = k[0];
      cfgUpperLeft = k[1];
      inZ = k[0] ? 32'h3F800000 : 32'h0;
      frag(16'h0105, 16'h0105, 32'h00020000);
      chk(fsPosX, k[0] ? 16'h00FD : 16'h0105);
      chk(fsPosY, (k[1] ? 16'h053B : 16'h0105) - (k[0] ? 16'h0008 : 16'h0));
      chk(fsPosZ, inZ);
      chk(fsPosW, 32'h00008000);
    end
    frag(16'h0010, 16'h0010, 32'h00010000);
    chk(fsPosW, 32'h00010000);
    frag(16'h0010, 16'h0010, 32'h00000001);
    chk(fsPosW, 32'hFFFFFFFF);
    frag(16'h0010, 16'h0010, 32'hFFFE0000);
    chk(fsPosW, 32'hFFFF8000);
    $display("coords done");
  endtask : testCoords

  task automatic testColourFront();
    logic [4:0] tbl [5] = '{5'h18, 5'h0C, 5'h0A, 5'h1D, 5'h14};
    inPrimary = {32'h000000FF, 32'h0, 32'h000000FF, 32'h0};
    inSecondary = inPrimary;
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimary[0], 32'h0);
    chk(fsPrimary[1], 32'h3F800000);
    chk(fsSecondary[3], 32'h3F800000);
    cfgColourIsFloat = 1'h1;
    inPrimary[2] = 32'h40400000;
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimary[2], 32'h40400000);
    // each entry: expected flag, then polygon, negative, zero, reversed
    foreach (tbl[i]) begin
      {inFromPoly, inAreaNeg, inAreaZero, cfgWindingRev} = tbl[i][3:0];
      frag(16'h0010, 16'h0010, 32'h00020000);
      chk(fsFront, tbl[i][4]);
    end
    $display("colour and facing done");
  endtask : testColourFront

  task automatic testPrimId();
    pulse(drawBegin);
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimId, 32'h0);
    pulse(primEnd);
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimId, 32'h1);
    primPartial = 1'h1;
    pulse(primEnd);
    primPartial = 1'h0;
    pulse(primRestart);
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimId, 32'h1);
    drawBegin = 1'h1;
    pulse(primEnd);
    drawBegin = 1'h0;
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimId, 32'h0);
    cfgGeomActive = 1'h1;
    inGeomPrimId = 32'h0000ABCD;
    frag(16'h0010, 16'h0010, 32'h00020000);
    chk(fsPrimId, 32'h0000ABCD);
    $display("primitive index done");
  endtask : testPrimId

  task automatic outCase(input fsio_fmt_t f, input logic c, input logic i,
                         input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
    cfgColourFmt = f;
    cfgClampEn = c;
    cfgOutIsInt = {3'h0, i};
    shade();
    chk(outColour[0][0], e0);
    chk(outColour[0][1], e1);
    chk(outColour[0][2], e2);
  endtask : outCase

  task automatic testOut();
    shColour[0] = {32'h3F800000, 32'h3F000000, 32'h40000000, 32'hBF800000};
    outCase(FSIO_FMT_FLOAT, 1'h1, 1'h0, 32'h0, 32'h3F800000, 32'h3F000000);
    outCase(FSIO_FMT_FLOAT, 1'h0, 1'h0, 32'hBF800000, 32'h40000000, 32'h3F000000);
    outCase(FSIO_FMT_INT, 1'h1, 1'h0, 32'hBF800000, 32'h40000000, 32'h3F000000);
    outCase(FSIO_FMT_FLOAT, 1'h1, 1'h1, 32'hBF800000, 32'h40000000, 32'h3F000000);
    outCase(FSIO_FMT_UNORM, 1'h1, 1'h0, 32'h0, 32'h000000FF, 32'h00000080);
    outCase(FSIO_FMT_SNORM, 1'h1, 1'h0, 32'h0, 32'h0000007F, 32'h00000040);
    outCase(FSIO_FMT_SNORM, 1'h0, 1'h0, 32'h00000081, 32'h0000007F, 32'h00000040);
    cfgWritesDepth = 1'h1;
    foreach (shColour[i]) begin
      shDepth = i[1] ? 32'hBF800000 : (i[0] ? 32'h3F000000 : 32'h40000000);
      shade();
      chk(outDepth, i[1] ? 32'h0 : (i[0] ? 32'h00800000 : 32'h00FFFFFF));
    end
    cfgDepthFloat = 1'h1;
    shDepth = 32'h40000000;
    shade();
    chk(outDepth, 32'h3F800000);
    cfgWritesDepth = 1'h0;
    shRasterDepth = 32'h12345678;
    shade();
    chk(outDepth, 32'h12345678);
    $display("output resolve done");
  endtask : testOut

  task automatic bindTo(input logic [1:0] v, input logic [7:0] n, input logic e);
    bindVar = v;
    bindNumber = n;
    pulse(bindValid);
    chk(bindError, e);
  endtask : bindTo

  task automatic linkAs(input logic [3:0] a, input logic f);
    linkActive = a;
    pulse(linkValid);
    chk(linkDone, 1'h1);
    chk(linkFail, f);
  endtask : linkAs

  task automatic query(input logic [1:0] v, input logic [7:0] e);
    queryVar = v;
    step(2);
    chk(queryNumber, e);
  endtask : query

  task automatic testLink();
    cfgColourFmt = FSIO_FMT_FLOAT;
    cfgClampEn = 1'h0;
    cfgOutIsInt = '0;
    bindTo(2'h0, 8'h04, 1'h1);
    bindTo(2'h1, 8'h03, 1'h0);
    bindTo(2'h1, 8'h02, 1'h0);
    linkAs(4'h3, 1'h0);
    query(2'h0, 8'h00);
    query(2'h1, 8'h02);
    cfgPrimaryOnly = 1'h0;
    shColour[1][0] = 32'h11111111;
    shade();
    chk(outColour[2][0], 32'h11111111);
    chk(outColour[0][1], 32'h40000000);
    bindTo(2'h0, 8'h02, 1'h0);
    linkAs(4'h3, 1'h1);
    query(2'h1, 8'hFF);
    bindTo(2'h0, 8'h00, 1'h0);
    cfgDrawLimit = 3'h2;
    linkAs(4'h7, 1'h1);
    $display("bind and link done");
  endtask : testLink

  // a slow consumer must see every output stand, and no new take meanwhile
  task automatic testStall();
    stall = 1'h1;
    frag(16'h0105, 16'h0105, 32'h00020000);
    step(2);
    chk(fsValid, 1'h1);
    chk(inReady, 1'h0);
    chk(fsPosW, 32'h00008000);
    shade();
    step(2);
    chk(outValid, 1'h1);
    chk(shReady, 1'h0);
    step(4);
    stall = 1'h0;
    $display("stall done");
  endtask : testStall

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tallyAndFinish

  // watchdog: the whole run needs about a thirteenth of this span
  initial begin
    #50000;
    failCount++;
    tallyAndFinish();
  end

  initial begin
    step(2);
    srst = 1'h0;
    chk(inReady, 1'h1);
    chk(queryNumber, 8'hFF);
    testCoords();
    testColourFront();
    testPrimId();
    testOut();
    testLink();
    testStall();
    tallyAndFinish();
  end
endmodule : tb
`default_nettype wire
